/* core/fdc_cmd_if.sv */
// parsed command fields passed to the result builder
interface fdc_cmd_if;
    logic [7:0]  opcode;
    logic [1:0]  driveSel;
    logic        headSel;
    logic [11:0] cyl;
    logic        wideTrack;
    logic [7:0]  st0;
    logic [7:0]  st3;
    logic [2:0]  index;
    logic [7:0]  resByte;
    logic [2:0]  resLen;
    modport src (output opcode, driveSel, headSel, cyl, wideTrack, st0, st3, index,
                 input resByte, resLen);
    modport bld (input opcode, driveSel, headSel, cyl, wideTrack, st0, st3, index,
                 output resByte, resLen);
endinterface : fdc_cmd_if

/* core/fdc_cmd_pkg.sv */
// constants shared by the command field decoder
package fdc_cmd_pkg;
    localparam logic [7:0] OP_READ_DATA     = 8'h06;
    localparam logic [7:0] OP_READ_DELETED  = 8'h0c;
    localparam logic [7:0] OP_WRITE_DATA    = 8'h05;
    localparam logic [7:0] OP_WRITE_DELETED = 8'h09;
    localparam logic [7:0] OP_READ_TRACK    = 8'h02;
    localparam logic [7:0] OP_READ_ID       = 8'h0a;
    localparam logic [7:0] OP_FORMAT        = 8'h0d;
    localparam logic [7:0] OP_SCAN_EQ       = 8'h11;
    localparam logic [7:0] OP_SCAN_LE       = 8'h19;
    localparam logic [7:0] OP_SCAN_HE       = 8'h1d;
    localparam logic [7:0] OP_SENSE_DRIVE   = 8'h04;
    localparam logic [7:0] OP_SPECIFY       = 8'h03;
    localparam logic [7:0] OP_SEEK          = 8'h0f;
    localparam logic [7:0] OP_RECAL         = 8'h07;
    localparam logic [7:0] OP_SENSE_INT     = 8'h08;
    localparam logic [7:0] OP_MODE          = 8'h01;
    localparam logic [7:0] OP_SET_TRACK     = 8'h21;
    // opcode and drive byte field positions
    localparam int MULTI_SIDE_BIT  = 7;
    localparam int DENSITY_BIT     = 6;
    localparam int BYPASS_BIT      = 5;
    localparam int SET_TRACK_DIR   = 6;
    localparam int AUTO_SEEK_BIT   = 7;
    localparam int HEAD_BIT        = 2;
    localparam int TRACK_MSB_SEL   = 2;
    // mode bytes 2 to 5 fields
    localparam int MODE_TIMER_BIT  = 0;
    localparam int MODE_INDEX_BIT  = 1;
    localparam int MODE_POWER_LSB  = 4;
    localparam int MODE_AUTO_SEEK  = 6;
    localparam int MODE_WIDE_TRACK = 0;
    localparam int MODE_WILDCARD   = 0;
    localparam int MODE_READ_GATE  = 1;
    localparam int MODE_PUMP_OUT   = 3;
    localparam logic [7:0] INVALID_ST0 = 8'h80;
    localparam int MODE_LEN        = 5;
    localparam int DATA_CMD_LEN    = 9;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_PARAM  = 4'b0010,
        ST_EXEC   = 4'b0100,
        ST_RESULT = 4'b1000
    } phase_e;
endpackage : fdc_cmd_pkg

/* core/fdc_command_field_decoder.sv */
// command byte decoder with mode and track state
module fdc_command_field_decoder
    import fdc_cmd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStrobe,
    input  wire logic       rdStrobe,
    input  wire logic       execDone,
    input  wire logic [7:0] driveStatus,
    output logic [7:0]      rdData,
    output logic            resultReady,
    output logic            execStart,
    output logic [1:0]      drive_select_code,
    output logic            head_select,
    output logic            multi_side_cycle,
    output logic            double_density_select,
    output logic            bypass_marked_sector,
    output logic            autoSeek,
    output logic            motor_head_timer_mode,
    output logic            index_field_format,
    output logic [1:0]      low_power_setting,
    output logic            wide_track_range_enable,
    output logic            scan_wildcard_enable,
    output logic            read_gate_input_enable,
    output logic            loop_filter_current_enable,
    output logic [7:0]      xferLength
);
    import fdc_cmd_pkg::*;

    phase_e      phase_q;
    logic [7:0]  op_q;
    logic [3:0]  cnt_q;
    logic [3:0]  need;
    logic [7:0]  params_q [0:8];
    logic [11:0] cyl_q [0:3];
    logic        autoSeekMode_q;
    logic [2:0]  resIdx_q;
    logic [7:0]  setTrackVal_q;
    logic        isSetTrack;
    logic        known;
    fdc_cmd_if   cmd ();

    // bit6 is the direction, so both forms must match
    assign isSetTrack = ({op_q[7], 1'b0, op_q[5:0]} == OP_SET_TRACK);
    assign known = (op_q[4:0] == OP_READ_DATA[4:0]) || (op_q[4:0] == OP_READ_DELETED[4:0])
        || (op_q[4:0] == OP_WRITE_DATA[4:0]) || (op_q[4:0] == OP_WRITE_DELETED[4:0])
        || (op_q[4:0] == OP_READ_TRACK[4:0]) || (op_q[4:0] == OP_READ_ID[4:0])
        || (op_q[4:0] == OP_FORMAT[4:0]) || (op_q[4:0] == OP_SCAN_EQ[4:0])
        || (op_q[4:0] == OP_SCAN_LE[4:0]) || (op_q[4:0] == OP_SCAN_HE[4:0])
        || (op_q == OP_SENSE_DRIVE) || (op_q == OP_SPECIFY) || (op_q == OP_SEEK)
        || (op_q == OP_RECAL) || (op_q == OP_SENSE_INT) || (op_q == OP_MODE) || isSetTrack;

    // total bytes including opcode; seek adds a byte in wide mode
    always_comb begin
        need = 4'd1;
        if (op_q == OP_MODE) begin
            need = 4'(MODE_LEN);
        end else if (op_q == OP_SEEK) begin
            need = wide_track_range_enable ? 4'd4 : 4'd3;
        end else if (isSetTrack) begin
            need = 4'd3;
        end else if (op_q == OP_SPECIFY) begin
            need = 4'd3;
        end else if (op_q == OP_RECAL || op_q == OP_SENSE_DRIVE || op_q == OP_READ_ID) begin
            need = 4'd2;
        end else if (op_q[4:0] == OP_FORMAT[4:0]) begin
            need = 4'd6;
        end else if (known && op_q != OP_SENSE_INT) begin
            need = 4'(DATA_CMD_LEN);
        end
    end

    assign cmd.opcode    = op_q;
    assign cmd.driveSel  = drive_select_code;
    assign cmd.headSel   = head_select;
    assign cmd.cyl       = cyl_q[drive_select_code];
    assign cmd.wideTrack = wide_track_range_enable;
    assign cmd.st0       = known ? {6'h00, drive_select_code} : INVALID_ST0;
    assign cmd.st3       = {driveStatus[7:3], head_select, drive_select_code};
    assign cmd.index     = resIdx_q;

    fdc_result_builder u_builder (
        .r (cmd)
    );

    // phase sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q   <= ST_IDLE;
            op_q      <= 8'h00;
            cnt_q     <= 4'd0;
            resIdx_q  <= 3'd0;
            execStart <= 1'b0;
        end else begin
            execStart <= 1'b0;
            case (phase_q)
                ST_IDLE: begin
                    if (wrStrobe) begin
                        op_q   <= wrData;
                        cnt_q  <= 4'd1;
                        phase_q <= ST_PARAM;
                    end
                end
                ST_PARAM: begin
                    if (cnt_q >= need) begin
                        resIdx_q <= 3'd0;
                        if (!known || op_q == OP_SENSE_DRIVE || op_q == OP_SENSE_INT
                            || isSetTrack) begin
                            phase_q <= ST_RESULT;
                        end else if (op_q == OP_MODE || op_q == OP_SPECIFY) begin
                            phase_q <= ST_IDLE;
                        end else begin
                            execStart <= 1'b1;
                            phase_q   <= ST_EXEC;
                        end
                    end else if (wrStrobe) begin
                        cnt_q <= cnt_q + 4'd1;
                    end
                end
                ST_EXEC: begin
                    if (execDone || wrStrobe) begin
                        phase_q <= ST_RESULT;
                    end
                end
                default: begin
                    if (rdStrobe) begin
                        if (resIdx_q + 3'd1 >= cmd.resLen) begin
                            phase_q <= ST_IDLE;
                        end
                        resIdx_q <= resIdx_q + 3'd1;
                    end
                end
            endcase
        end
    end

    // parameter capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 9; i++) begin
                params_q[i] <= 8'h00;
            end
        end else if (phase_q == ST_PARAM && wrStrobe && cnt_q < 4'd9) begin
            params_q[cnt_q] <= wrData;
        end
    end

    // mode register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            autoSeekMode_q             <= 1'b0;
            motor_head_timer_mode      <= 1'b0;
            index_field_format         <= 1'b0;
            low_power_setting          <= 2'b00;
            wide_track_range_enable    <= 1'b0;
            scan_wildcard_enable       <= 1'b0;
            read_gate_input_enable     <= 1'b0;
            loop_filter_current_enable <= 1'b0;
        end else if (phase_q == ST_PARAM && op_q == OP_MODE && cnt_q >= need) begin
            autoSeekMode_q          <= params_q[1][MODE_AUTO_SEEK];
            low_power_setting       <= params_q[1][MODE_POWER_LSB +: 2];
            index_field_format      <= params_q[1][MODE_INDEX_BIT];
            motor_head_timer_mode   <= params_q[1][MODE_TIMER_BIT];
            wide_track_range_enable <= params_q[2][MODE_WIDE_TRACK];
            scan_wildcard_enable    <= params_q[3][MODE_WILDCARD];
            read_gate_input_enable     <= params_q[4][MODE_READ_GATE];
            loop_filter_current_enable <= params_q[4][MODE_PUMP_OUT];
        end
    end

    // command field latches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_select_code     <= 2'b00;
            head_select           <= 1'b0;
            multi_side_cycle      <= 1'b0;
            double_density_select <= 1'b0;
            bypass_marked_sector  <= 1'b0;
            autoSeek              <= 1'b0;
            xferLength            <= 8'h00;
        end else if (phase_q == ST_PARAM && cnt_q >= need && known) begin
            drive_select_code     <= params_q[1][1:0];
            head_select           <= params_q[1][HEAD_BIT];
            double_density_select <= op_q[DENSITY_BIT];
            multi_side_cycle      <= op_q[MULTI_SIDE_BIT];
            bypass_marked_sector  <= op_q[BYPASS_BIT];
            autoSeek              <= autoSeekMode_q & params_q[1][AUTO_SEEK_BIT];
            xferLength            <= (params_q[5] == 8'h00) ? params_q[8] : 8'h00;
        end
    end

    // per-drive cylinder values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                cyl_q[i] <= 12'h000;
            end
            setTrackVal_q <= 8'h00;
        end else if (phase_q == ST_PARAM && cnt_q >= need) begin
            if (op_q == OP_SEEK) begin
                cyl_q[params_q[1][1:0]] <= {wide_track_range_enable ? params_q[3][7:4] : 4'h0,
                                            params_q[2]};
            end else if (op_q == OP_RECAL) begin
                cyl_q[params_q[1][1:0]] <= 12'h000;
            end else if (isSetTrack) begin
                if (op_q[SET_TRACK_DIR]) begin
                    if (params_q[1][TRACK_MSB_SEL]) begin
                        cyl_q[params_q[1][1:0]][11:8] <= params_q[2][3:0];
                    end else begin
                        cyl_q[params_q[1][1:0]][7:0] <= params_q[2];
                    end
                    setTrackVal_q <= params_q[2];
                end else begin
                    setTrackVal_q <= params_q[1][TRACK_MSB_SEL]
                        ? {4'h0, cyl_q[params_q[1][1:0]][11:8]}
                        : cyl_q[params_q[1][1:0]][7:0];
                end
            end
        end
    end

    // read data and result flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData      <= 8'h00;
            resultReady <= 1'b0;
        end else begin
            resultReady <= (phase_q == ST_RESULT);
            if (rdStrobe) begin
                rdData <= (phase_q == ST_RESULT)
                    ? (isSetTrack ? setTrackVal_q : cmd.resByte) : 8'h00;
            end
        end
    end

    AST_SEEK_GATE: assert property (@(posedge clk) disable iff (rst)
        autoSeek |-> autoSeekMode_q) else $error("auto seek without mode enable");
    AST_ABORT: assert property (@(posedge clk) disable iff (rst)
        (phase_q == ST_EXEC && wrStrobe) |=> phase_q == ST_RESULT) else $error("no abort");

    AST_SEEK_OFF: assert property (@(posedge clk) disable iff (rst)
        (phase_q == ST_PARAM && cnt_q >= need && known && !autoSeekMode_q) |=> !autoSeek)
        else $error("auto seek latched while mode disabled");

    AST_INVALID_SKIP: assert property (@(posedge clk) disable iff (rst)
        (phase_q == ST_PARAM && cnt_q >= need && !known)
        |=> (phase_q == ST_RESULT && !execStart)) else $error("invalid opcode executed");

    AST_SENSE_DRIVE: assert property (@(posedge clk) disable iff (rst)
        (phase_q == ST_PARAM && cnt_q >= need && op_q == OP_SENSE_DRIVE)
        |=> (phase_q == ST_RESULT && cmd.resLen == 3'd1)) else $error("sense drive result wrong");

    AST_NIBBLE_LOW: assert property (@(posedge clk) disable iff (rst)
        (rdStrobe && phase_q == ST_RESULT && op_q == OP_SENSE_INT && resIdx_q == 3'd2)
        |=> rdData[3:0] == 4'h0) else $error("track high byte has low bits set");

    AST_TRACK_WRITE: assert property (@(posedge clk) disable iff (rst)
        (phase_q == ST_PARAM && cnt_q >= need && isSetTrack && op_q[SET_TRACK_DIR]
            && !params_q[1][TRACK_MSB_SEL])
        |=> cmd.cyl[7:0] == $past(params_q[2])) else $error("set-track write not stored");

    AST_XFER_ZERO: assert property (@(posedge clk) disable iff (rst)
        (phase_q == ST_PARAM && cnt_q >= need && known && params_q[5] != 8'h00)
        |=> xferLength == 8'h00) else $error("data length used with nonzero size");
endmodule : fdc_command_field_decoder

/* core/fdc_result_builder.sv */
// combinational result byte selector
module fdc_result_builder
    import fdc_cmd_pkg::*;
(
    fdc_cmd_if.bld r
);
    always_comb begin
        r.resByte = 8'h00;
        r.resLen  = 3'd1;
        if (r.opcode == OP_SENSE_INT) begin
            r.resLen = r.wideTrack ? 3'd3 : 3'd2;
            if (r.index == 3'd0) begin
                r.resByte = r.st0;
            end else if (r.index == 3'd1) begin
                r.resByte = r.cyl[7:0];
            end else begin
                r.resByte = {r.cyl[11:8], 4'h0};
            end
        end else if ({r.opcode[7], 1'b0, r.opcode[5:0]} == OP_SET_TRACK) begin
            r.resByte = r.st0;
        end else if (r.opcode == OP_SENSE_DRIVE) begin
            r.resByte = r.st3;
        end else begin
            r.resByte = r.st0;
        end
    end
endmodule : fdc_result_builder

/* verification/fdc_command_field_decoder_tb.sv */
// self-checking bench for the command field decoder
module fdc_command_field_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fdc_cmd_pkg::*;

    typedef struct packed {
        logic [7:0] m1, m3, m4, op, b2, sz, dl, xl;
        logic       as;
    } row_s;

    logic       clk, rst, wrStrobe, rdStrobe, execDone, resultReady, execStart;
    logic [7:0] wrData, driveStatus, rdData, xferLength;
    logic [1:0] drive_select_code, low_power_setting;
    logic       head_select, multi_side_cycle, double_density_select;
    logic       bypass_marked_sector, autoSeek, motor_head_timer_mode;
    logic       index_field_format, wide_track_range_enable, scan_wildcard_enable;
    logic       read_gate_input_enable, loop_filter_current_enable;
    logic [7:0] cmd [9];
    logic [7:0] res [8];
    row_s       rows [4];
    row_s       r;
    int         nres, badCount, totalChecks;

    fdc_command_field_decoder DUT (
        .clk, .rst, .wrData, .wrStrobe, .rdStrobe, .execDone, .driveStatus,
        .rdData, .resultReady, .execStart, .drive_select_code, .head_select,
        .multi_side_cycle, .double_density_select, .bypass_marked_sector,
        .autoSeek, .motor_head_timer_mode, .index_field_format,
        .low_power_setting, .wide_track_range_enable, .scan_wildcard_enable,
        .read_gate_input_enable, .loop_filter_current_enable, .xferLength
    );

    fdc_host_model hostModel (.clk, .rdData, .wrData, .wrStrobe, .rdStrobe);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // sel 0 waits for execStart, sel 1 for resultReady
    task automatic wait_hi(input bit sel);
        int i = 0;
        #1;
        while (i < 40 && (sel ? resultReady : execStart) !== 1'b1) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i == 40) begin
            badCount++;
            $display("BAD wait%0d expected 1 seen 0", sel);
            report_and_stop();
        end
    endtask : wait_hi

    task automatic drain;
        nres = 0;
        wait_hi(1'b1);
        while (resultReady === 1'b1 && nres < 8) begin
            hostModel.get(res[nres]);
            nres++;
            // the ready flag lags the last read by one edge
            @(posedge clk);
            #1;
        end
    endtask : drain

    task automatic mode(input logic [7:0] a, b, c, d);
        cmd = '{OP_MODE, a, b, c, d, 8'h00, 8'h00, 8'h00, 8'h00};
        hostModel.send(cmd, MODE_LEN);
        repeat (2) @(posedge clk);
    endtask : mode

    task automatic data_cmd(input logic [7:0] op, b2, sz, dl);
        cmd = '{op, b2, 8'h05, {7'h00, b2[2]}, 8'h01, sz, 8'h09, 8'h1b, dl};
        hostModel.send(cmd, DATA_CMD_LEN);
        wait_hi(1'b0);
    endtask : data_cmd

    initial begin
        rst         = 1'b1;
        execDone    = 1'b0;
        driveStatus = 8'ha8;
        badCount    = 0;
        totalChecks = 0;
        rows[0] = '{8'h00, 8'h00, 8'h00, OP_READ_DATA | 8'he0, 8'h85, 8'h00, 8'h40, 8'h40, 1'b0};
        rows[1] = '{8'h73, 8'h01, 8'h0a, OP_WRITE_DELETED | 8'h40, 8'h82, 8'h02, 8'hff, 8'h00, 1'b1};
        rows[2] = '{8'h50, 8'h00, 8'h02, OP_SCAN_EQ | 8'ha0, 8'h07, 8'h00, 8'h10, 8'h10, 1'b0};
        rows[3] = '{8'h22, 8'h00, 8'h08, OP_READ_DELETED | 8'h20, 8'h80, 8'h01, 8'hff, 8'h00, 1'b0};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[k]) begin
            r = rows[k];
            mode(r.m1, 8'h00, r.m3, r.m4);
            data_cmd(r.op, r.b2, r.sz, r.dl);
            check("modeBits", {motor_head_timer_mode, index_field_format, low_power_setting,
                  scan_wildcard_enable, read_gate_input_enable, loop_filter_current_enable,
                  wide_track_range_enable}, {r.m1[0], r.m1[1], r.m1[5:4], r.m3[0], r.m4[1],
                  r.m4[3], 1'b0});
            check("drive", {drive_select_code, head_select}, {r.b2[1:0], r.b2[2]});
            check("opBits", {multi_side_cycle, double_density_select, bypass_marked_sector},
                  r.op[7:5]);
            check("autoSeek", autoSeek, r.as);
            check("xferLen", xferLength, r.xl);
            @(posedge clk) execDone <= 1'b1;
            @(posedge clk) execDone <= 1'b0;
            drain();
            check("dataResLen", nres, 1);
        end
        // write high then low track byte of drive 0
        cmd = '{OP_SET_TRACK | 8'h40, 8'h34, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        hostModel.send(cmd, 3);
        drain();
        cmd[1] = 8'h30;
        cmd[2] = 8'h5c;
        hostModel.send(cmd, 3);
        drain();
        // read form must not disturb the stored value
        cmd = '{OP_SET_TRACK, 8'h34, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        hostModel.send(cmd, 3);
        drain();
        check("trackHi", res[0], 8'h0a);
        cmd[1] = 8'h30;
        hostModel.send(cmd, 3);
        drain();
        check("trackLo", res[0], 8'h5c);
        cmd[0] = OP_SENSE_INT;
        hostModel.send(cmd, 1);
        drain();
        check("intLen", nres, 2);
        check("intCyl", res[1], 8'h5c);
        mode(8'h00, 8'h01, 8'h00, 8'h00);
        check("wide", wide_track_range_enable, 1'b1);
        cmd[0] = OP_SENSE_INT;
        hostModel.send(cmd, 1);
        drain();
        check("intWide", {nres[3:0], res[1], res[2]}, {4'h3, 8'h5c, 8'ha0});
        // wide seek carries the high nibble in a fourth byte
        cmd = '{OP_SEEK, 8'h01, 8'h34, 8'hb0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        hostModel.send(cmd, 4);
        wait_hi(1'b0);
        @(posedge clk) execDone <= 1'b1;
        @(posedge clk) execDone <= 1'b0;
        drain();
        cmd[0] = OP_SENSE_INT;
        hostModel.send(cmd, 1);
        drain();
        check("seekWide", {nres[3:0], res[1], res[2]}, {4'h3, 8'h34, 8'hb0});
        cmd[0] = OP_SENSE_DRIVE;
        cmd[1] = 8'h06;
        hostModel.send(cmd, 2);
        drain();
        check("st3", {nres[3:0], res[0]}, {4'h1, 8'hae});
        check("st3Drive", {drive_select_code, head_select}, 3'b101);
        cmd[0] = 8'h1f;
        hostModel.send(cmd, 1);
        drain();
        check("invalid", {nres[3:0], res[0]}, {4'h1, INVALID_ST0});
        hostModel.get(res[0]);
        check("idleRead", res[0], 8'h00);
        // stalled transfer: a stray byte must push it into the result phase
        data_cmd(OP_READ_DATA, 8'h00, 8'h02, 8'hff);
        cmd[0] = 8'h00;
        hostModel.send(cmd, 1);
        drain();
        check("abortLen", nres, 1);
        mode(8'h73, 8'h01, 8'h01, 8'h0a);
        cmd[0] = OP_SENSE_INT;
        hostModel.send(cmd, 1);
        wait_hi(1'b1);
        @(posedge clk) rst <= 1'b1;
        #1;
        check("rstData", {rdData, xferLength}, 16'h0000);
        check("rstFlags", {resultReady, execStart, drive_select_code, head_select,
              multi_side_cycle, double_density_select, bypass_marked_sector, autoSeek,
              motor_head_timer_mode, index_field_format, low_power_setting,
              wide_track_range_enable, scan_wildcard_enable, read_gate_input_enable,
              loop_filter_current_enable}, 17'h00000);
        @(posedge clk) rst <= 1'b0;
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule : fdc_command_field_decoder_tb

/* verification/fdc_host_model.sv */
// host side model: writes command bytes and reads result bytes
module fdc_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdData,
    output logic [7:0]      wrData,
    output logic            wrStrobe,
    output logic            rdStrobe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wrData   = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    // first n bytes of the command list
    // bytes go out back to back; the caller lists every parameter
    task automatic send(input logic [7:0] b [9], input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            wrData   <= b[i];
            wrStrobe <= 1'b1;
            @(posedge clk);
        end
        wrStrobe <= 1'b0;
        // stale data would hide a decoder that samples without the strobe
        wrData   <= ~b[n-1];
    endtask : send

    task automatic get(output logic [7:0] v);
        @(posedge clk);
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 v = rdData;
    endtask : get
endmodule : fdc_host_model
